/* verilog/product_shift_regs.svh */
// Purpose: Register offsets, fields, reset values and opcodes of the product shifter block
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one aligned word per register
// Notes: Definitions only
`ifndef PRODUCT_SHIFT_REGS_SVH
`define PRODUCT_SHIFT_REGS_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_ACC 8'h08
`define OFS_PROD 8'h0c
`define OFS_MCAND 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_CLR 8'h18
`define OFS_IRQ_EN 8'h1c

// Field positions and interrupt field width
`define CTRL_SAT_BIT 0
`define STAT_WRAP_BIT 2
`define STAT_CARRY_BIT 3
`define IRQ_WRAP_BIT 0
`define IRQ_SQUARE_BIT 1
`define IRQ_LOAD_BIT 2
`define IRQ_WIDTH 3

// Reset values
`define RST_MODE 2'h0
`define RST_IRQ_EN 3'h0

// Opcode upper bytes; set-shift is the upper 14 bits
`define OPC_SQUARE_ACC 8'h52
`define OPC_SQUARE_SUB 8'h53
`define OPC_SET_SHIFT 14'h2fc0

// Right-shift mode scaling
`define RIGHT_SHIFT 6
`endif

/* verilog/shift_mac_pkg.sv */
// Purpose: Types shared by the product shifter block
// Assumes: Nothing beyond SystemVerilog
// Notes: Constants live in the register header
package shift_mac_pkg;
    // Product output shifter modes
    typedef enum logic [1:0] {
        SHIFT_NONE = 2'b00,
        SHIFT_LEFT1 = 2'b01,
        SHIFT_LEFT4 = 2'b10,
        SHIFT_RIGHT6 = 2'b11
    } shift_mode_t;
endpackage : shift_mac_pkg

/* verilog/product_shift_square_mac.sv */
// Purpose: Product output shifter, shift-mode setting and square-accumulate/subtract datapath
// Assumes: Decoder presents one instruction word and its operand in the same cycle
// Notes: AHB-Lite slave with zero wait states; level interrupt output
//
// Functional notes
// RQ1: Set-shift copies opcode low two bits
// RQ2: Modes: none, left1, left4, right6 signed
// RQ3: Load-status to word one updates mode
// RQ4: Set-shift ignored on repeated iterations
// RQ5: Mode persists for all later transfers
// RQ6: Right6 mode keeps 128 squares overflow-free
// RQ7: Square-accumulate adds shifted product first
// RQ8: Then latches operand, squares into product
// RQ9: Square-subtract subtracts shifted product first
// RQ10: Then latches operand, squares into product
// RQ11: Wrap and carry flags; saturation selectable
// RQ12: Decode opcodes 0x52, 0x53; bit7 indirect
// RQ13: Offset 0..127, aux 0..7, one word
`include "product_shift_regs.svh"

module product_shift_square_mac #(
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Instruction and operand from the decoder
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    input wire logic repeatIter,
    input wire logic [DATA_W-1:0] operandData,
    // Load-status path, word one
    input wire logic loadStatusValid,
    input wire logic [15:0] loadStatusWord,
    // Operand addressing and program counter step
    output logic operandIndirect,
    output logic [6:0] operandOffset,
    output logic [2:0] nextAuxPointer,
    output logic pcAdvance,
    // Accumulator side
    output logic [31:0] accumulator,
    output logic sumWrapFlag,
    output logic carryFlag,
    output logic [1:0] productShiftMode,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Interrupt
    output logic irq
);
    // Product and multiplicand state
    logic [31:0] product;
    logic [DATA_W-1:0] multiplicandLatch;
    logic saturateOnWrap; // Control bit from software
    logic [`IRQ_WIDTH-1:0] irqStatus;
    logic [`IRQ_WIDTH-1:0] irqEnable;

    // Decode of the current instruction word
    logic isSquareAcc;
    logic isSquareSub;
    logic isSquare;
    logic isSetShift;
    assign isSquareAcc = instrValid && instrWord[15:8] == `OPC_SQUARE_ACC; // RQ12
    assign isSquareSub = instrValid && instrWord[15:8] == `OPC_SQUARE_SUB; // RQ12
    assign isSquare = isSquareAcc || isSquareSub;
    assign isSetShift = instrValid && instrWord[15:2] == `OPC_SET_SHIFT && !repeatIter; // RQ4

    // Product output shifter
    logic [31:0] shiftedProduct;
    always_comb begin
        case (shift_mac_pkg::shift_mode_t'(productShiftMode)) // RQ5
            shift_mac_pkg::SHIFT_NONE: begin
                shiftedProduct = product; // RQ2
            end
            shift_mac_pkg::SHIFT_LEFT1: begin
                shiftedProduct = {product[30:0], 1'b0}; // RQ2
            end
            shift_mac_pkg::SHIFT_LEFT4: begin
                shiftedProduct = {product[27:0], 4'h0}; // RQ2
            end
            shift_mac_pkg::SHIFT_RIGHT6: begin
                shiftedProduct = 32'($signed(product) >>> `RIGHT_SHIFT); // RQ2 RQ6
            end
            default: begin
                shiftedProduct = product;
            end
        endcase
    end

    // Accumulator adder or subtractor with carry and overflow
    logic [31:0] addend;
    logic [32:0] rawSum;
    logic sumWrap;
    logic [31:0] next_accumulator;
    assign addend = isSquareSub ? ~shiftedProduct : shiftedProduct; // RQ9
    assign rawSum = {1'b0, accumulator} + {1'b0, addend} + {32'h0, isSquareSub}; // RQ7 RQ9
    assign sumWrap = (accumulator[31] == addend[31]) && (rawSum[31] != accumulator[31]); // RQ11
    always_comb begin
        if (sumWrap && saturateOnWrap) begin
            next_accumulator = accumulator[31] ? 32'h80000000 : 32'h7fffffff; // RQ11
        end else begin
            next_accumulator = rawSum[31:0];
        end
    end

    // Squared operand
    logic signed [31:0] operandWide; // Operand sign-extended before the multiply
    logic [31:0] square;
    // Widen first so the product is not cut to the operand width
    assign operandWide = 32'($signed(operandData));
    assign square = 32'(operandWide * operandWide); // RQ8 RQ10

    // Accumulator, flags and product update on square instructions
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            accumulator <= 32'h0;
            carryFlag <= 1'b0;
            product <= 32'h0;
            multiplicandLatch <= '0;
        end else if (isSquare) begin
            accumulator <= next_accumulator; // RQ7 RQ9
            carryFlag <= rawSum[32]; // RQ11
            multiplicandLatch <= operandData; // RQ8 RQ10
            product <= square; // RQ8 RQ10
        end
    end

    // Bus address phase capture
    logic busWrite;
    logic [7:0] busAddr;
    logic addrPhase;
    assign addrPhase = hsel && hready && htrans[1];
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busWrite <= 1'b0;
            busAddr <= 8'h0;
        end else if (hready) begin
            busWrite <= addrPhase && hwrite;
            busAddr <= haddr[7:0];
        end
    end

    // Data phase write strobes
    logic wrCtrl;
    logic wrStat;
    logic wrIrqClr;
    logic wrIrqEn;
    assign wrCtrl = busWrite && busAddr == `OFS_CTRL;
    assign wrStat = busWrite && busAddr == `OFS_STAT;
    assign wrIrqClr = busWrite && busAddr == `OFS_IRQ_CLR;
    assign wrIrqEn = busWrite && busAddr == `OFS_IRQ_EN;

    // Shift mode field of status word one
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            productShiftMode <= `RST_MODE;
        end else if (isSetShift) begin
            productShiftMode <= instrWord[1:0]; // RQ1
        end else if (loadStatusValid) begin
            productShiftMode <= loadStatusWord[1:0]; // RQ3
        end
    end

    // Sticky wrap flag; a new wrap wins over a software clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sumWrapFlag <= 1'b0;
        end else if (isSquare && sumWrap) begin
            sumWrapFlag <= 1'b1; // RQ11
        end else if (wrStat && hwdata[`STAT_WRAP_BIT]) begin
            sumWrapFlag <= 1'b0;
        end
    end

    // Control register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            saturateOnWrap <= 1'b0;
        end else if (wrCtrl) begin
            saturateOnWrap <= hwdata[`CTRL_SAT_BIT];
        end
    end

    // Operand addressing outputs and program counter step
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            operandIndirect <= 1'b0;
            operandOffset <= 7'h0;
            nextAuxPointer <= 3'h0;
            pcAdvance <= 1'b0;
        end else begin
            pcAdvance <= isSquare || isSetShift; // RQ13
            if (isSquare) begin
                operandIndirect <= instrWord[7]; // RQ12
                operandOffset <= instrWord[6:0]; // RQ13
                nextAuxPointer <= instrWord[2:0]; // RQ13
            end
        end
    end

    // Interrupt events
    logic [`IRQ_WIDTH-1:0] irqEvent;
    assign irqEvent[`IRQ_WRAP_BIT] = isSquare && sumWrap;
    assign irqEvent[`IRQ_SQUARE_BIT] = isSquare;
    assign irqEvent[`IRQ_LOAD_BIT] = loadStatusValid;

    // Sticky status bits, set wins over clear
    genvar gi;
    generate
        for (gi = 0; gi < `IRQ_WIDTH; gi++) begin : gStatus
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    irqStatus[gi] <= 1'b0;
                end else if (irqEvent[gi]) begin
                    irqStatus[gi] <= 1'b1;
                end else if (wrIrqClr && hwdata[gi]) begin
                    irqStatus[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Interrupt enable register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irqEnable <= `RST_IRQ_EN;
        end else if (wrIrqEn) begin
            irqEnable <= hwdata[`IRQ_WIDTH-1:0];
        end
    end

    // Interrupt output from a flop
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus & irqEnable);
        end
    end

    // Read mux for the address phase
    logic [31:0] readValue;
    always_comb begin
        case (haddr[7:0])
            `OFS_CTRL: readValue = {31'h0, saturateOnWrap};
            `OFS_STAT: readValue = {28'h0, carryFlag, sumWrapFlag, productShiftMode};
            `OFS_ACC: readValue = accumulator;
            `OFS_PROD: readValue = product;
            `OFS_MCAND: readValue = 32'(multiplicandLatch);
            `OFS_IRQ_STAT: readValue = {29'h0, irqStatus};
            `OFS_IRQ_EN: readValue = {29'h0, irqEnable};
            default: readValue = 32'h0; // Unmapped and write-only read zero
        endcase
    end

    // Bus answer: zero wait, always OKAY
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addrPhase && !hwrite) begin
                hrdata <= readValue;
            end
        end
    end

    // Checks
    chk_set_mode: assert property (@(posedge mclk) disable iff (!nrst) // RQ1
        isSetShift |=> productShiftMode == $past(instrWord[1:0]))
        else $error("shift mode not taken from opcode");
    chk_repeat_block: assert property (@(posedge mclk) disable iff (!nrst) // RQ4
        (instrValid && repeatIter && instrWord[15:2] == `OPC_SET_SHIFT && !loadStatusValid)
        |=> $stable(productShiftMode))
        else $error("repeated set-shift changed mode");
    chk_load_mode: assert property (@(posedge mclk) disable iff (!nrst) // RQ3
        (loadStatusValid && !isSetShift) |=> productShiftMode == $past(loadStatusWord[1:0]))
        else $error("load-status did not set mode");
    chk_mode_hold: assert property (@(posedge mclk) disable iff (!nrst) // RQ5
        (!isSetShift && !loadStatusValid) |=> $stable(productShiftMode))
        else $error("shift mode changed by itself");
    chk_left4_shift: assert property (@(posedge mclk) disable iff (!nrst) // RQ2
        productShiftMode == 2'b10 |-> shiftedProduct == product << 4)
        else $error("left4 shift wrong");
    chk_right6_range: assert property (@(posedge mclk) disable iff (!nrst) // RQ2 RQ6
        productShiftMode == 2'b11 |-> shiftedProduct == {{6{product[31]}}, product[31:6]})
        else $error("right6 result not sign-extended");
    chk_acc_add: assert property (@(posedge mclk) disable iff (!nrst) // RQ7
        (isSquareAcc && !sumWrap) |=> accumulator == $past(accumulator) + $past(shiftedProduct))
        else $error("accumulate sum wrong");
    chk_acc_sub: assert property (@(posedge mclk) disable iff (!nrst) // RQ9
        (isSquareSub && !sumWrap) |=> accumulator == $past(accumulator) - $past(shiftedProduct))
        else $error("subtract result wrong");
    chk_square_load: assert property (@(posedge mclk) disable iff (!nrst) // RQ8
        isSquare |=> multiplicandLatch == $past(operandData)
        && product == 32'(32'($signed($past(operandData))) * 32'($signed($past(operandData)))))
        else $error("square not stored");
    chk_saturate: assert property (@(posedge mclk) disable iff (!nrst) // RQ11
        (isSquare && sumWrap && saturateOnWrap) |=> sumWrapFlag
        && (accumulator == 32'h7fffffff || accumulator == 32'h80000000))
        else $error("saturation or wrap flag wrong");
    chk_pc_step: assert property (@(posedge mclk) disable iff (!nrst) // RQ13
        isSquare |=> pcAdvance && operandOffset == $past(instrWord[6:0]))
        else $error("pc step or offset wrong");

    // Remaining shifter modes, exact values
    chk_none_shift: assert property (@(posedge mclk) disable iff (!nrst) // RQ2
        productShiftMode == 2'b00 |-> shiftedProduct == product)
        else $error("unshifted product wrong");
    chk_left1_shift: assert property (@(posedge mclk) disable iff (!nrst) // RQ2
        productShiftMode == 2'b01 |-> shiftedProduct == {product[30:0], 1'b0})
        else $error("left1 shift wrong");

    // Accumulator holds between square instructions
    chk_acc_hold: assert property (@(posedge mclk) disable iff (!nrst) // RQ7 RQ9
        !isSquare |=> $stable(accumulator))
        else $error("accumulator changed without a square");

    // Carry is the unsigned carry of the add, or no-borrow of the subtract
    chk_carry_add: assert property (@(posedge mclk) disable iff (!nrst) // RQ11
        isSquareAcc |=> carryFlag == ($past(accumulator) > ~$past(shiftedProduct)))
        else $error("carry after accumulate wrong");
    chk_carry_sub: assert property (@(posedge mclk) disable iff (!nrst) // RQ11
        isSquareSub |=> carryFlag == ($past(accumulator) >= $past(shiftedProduct)))
        else $error("no-borrow after subtract wrong");

    // Wrap flag is set by any wrap and stays until software clears it
    chk_wrap_set: assert property (@(posedge mclk) disable iff (!nrst) // RQ11
        (isSquare && sumWrap) |=> sumWrapFlag)
        else $error("wrap flag not set");
    chk_wrap_sticky: assert property (@(posedge mclk) disable iff (!nrst) // RQ11
        (sumWrapFlag && !(wrStat && hwdata[`STAT_WRAP_BIT])) |=> sumWrapFlag)
        else $error("wrap flag dropped without a clear");
endmodule : product_shift_square_mac

/* sim/operand_model.sv */
// Purpose: Decoder and data-memory operand model
// Assumes: One instruction issued a cycle after each request
// Notes: Operand lines show the inverted last value when idle
module operand_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Bench request
    input wire logic issue,
    input wire logic [15:0] issueWord,
    input wire logic issueRepeat,
    // Toward the block
    output logic instrValid,
    output logic [15:0] instrWord,
    output logic repeatIter,
    output logic [15:0] operandData
);
    timeunit 1ns;
    timeprecision 100ps;
    // Memory word at the direct offset, or at the fixed offset 7f when indirect
    function automatic logic [15:0] memWord(input logic [15:0] w);
        logic [6:0] a;
        a = w[7] ? 7'h7f : w[6:0];
        if (a == 7'h7f) return 16'hffff;
        if (a == 7'h40) return 16'h8000;
        return {9'h0, a};
    endfunction : memWord

    // Issue one word per request
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            instrValid <= 1'b0;
            instrWord <= 16'h0;
            repeatIter <= 1'b0;
            operandData <= 16'h0;
        end else begin
            instrValid <= issue;
            if (issue) begin
                instrWord <= issueWord;
                repeatIter <= issueRepeat;
                operandData <= memWord(issueWord);
            end else begin
                operandData <= ~operandData;
            end
        end
    end
endmodule : operand_model

/* sim/product_shift_square_mac_test.sv */
// Purpose: Self-checking bench of the product shifter block
// Assumes: Zero-wait bus slave, one instruction at a time
// Notes: Expected accumulator kept by a local model
`include "product_shift_regs.svh"
module product_shift_square_mac_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0, nrst = 1'b0, issue = 1'b0, issueRepeat = 1'b0;
    logic lsValid = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [15:0] issueWord = 16'h0, lsWord = 16'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, expAcc = 32'h0, expProd = 32'h0;
    logic [1:0] htrans = 2'h0, expMode = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic instrValid, repeatIter, opInd, pcAdv, wrap, carry, hrdy, hresp, irq, sat = 1'b0, expWrap = 1'b0;
    logic [15:0] instrWord, operandData;
    logic [6:0] opOfs;
    logic [2:0] auxPtr;
    logic [31:0] acc, hrdata;
    logic [1:0] mode;
    int errCount = 0, checksDone = 0;

    // Clock of 10 ns
    always #5 mclk = ~mclk;

    operand_model model (.mclk(mclk), .nrst(nrst), .issue(issue), .issueWord(issueWord),
        .issueRepeat(issueRepeat), .instrValid(instrValid), .instrWord(instrWord),
        .repeatIter(repeatIter), .operandData(operandData));

    product_shift_square_mac dut (.mclk(mclk), .nrst(nrst), .instrValid(instrValid),
        .instrWord(instrWord), .repeatIter(repeatIter), .operandData(operandData),
        .loadStatusValid(lsValid), .loadStatusWord(lsWord), .operandIndirect(opInd),
        .operandOffset(opOfs), .nextAuxPointer(auxPtr), .pcAdvance(pcAdv), .accumulator(acc),
        .sumWrapFlag(wrap), .carryFlag(carry), .productShiftMode(mode), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .irq(irq));

    // Verdict and end of run
    task automatic testDone();
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : testDone

    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Bounded wait for ready at a rising edge
    task automatic waitRdy();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hrdy !== 1'b1 && n < 50);
        if (hrdy !== 1'b1) begin
            errCount++;
            testDone();
        end
    endtask : waitRdy

    // One single word transfer; read data left in rd
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        waitRdy();
        htrans <= 2'b00;
        hwdata <= wd;
        waitRdy();
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : bus

    // Issue one instruction; returns just after the taking edge
    task automatic exec(input logic [15:0] w, input logic rep);
        @(posedge mclk);
        issue <= 1'b1;
        issueWord <= w;
        issueRepeat <= rep;
        @(posedge mclk);
        issue <= 1'b0;
        @(posedge mclk);
        #1;
    endtask : exec

    // Product shifter by mode
    function automatic logic [31:0] shiftP(input logic [31:0] p, input logic [1:0] m);
        case (m)
            2'h1: return p << 1;
            2'h2: return p << 4;
            2'h3: return 32'($signed(p) >>> 6);
            default: return p;
        endcase
    endfunction : shiftP

    // Set shift mode, plain or repeated
    task automatic setShift(input logic [1:0] m, input logic rep);
        exec({`OPC_SET_SHIFT, m}, rep);
        if (!rep) expMode = m;
        chk({30'h0, mode}, {30'h0, expMode});
    endtask : setShift

    // Square op with model of accumulator, flags and product
    task automatic sq(input logic [15:0] w, input logic [15:0] op);
        logic [31:0] sp;
        logic [32:0] sum;
        logic ov;
        sp = shiftP(expProd, expMode);
        sum = w[8] ? {1'b0, expAcc} + {1'b0, ~sp} + 33'h1 : {1'b0, expAcc} + {1'b0, sp};
        ov = (expAcc[31] == (w[8] ? ~sp[31] : sp[31])) && (sum[31] != expAcc[31]);
        exec(w, 1'b0);
        expAcc = (ov && sat) ? (expAcc[31] ? 32'h80000000 : 32'h7fffffff) : sum[31:0];
        expWrap = expWrap | ov;
        expProd = $signed(op) * $signed(op);
        chk(acc, expAcc);
        chk({30'h0, carry, wrap}, {30'h0, sum[32], expWrap});
        chk({20'h0, pcAdv, opInd, auxPtr, opOfs}, {20'h0, 1'b1, w[7], w[2:0], w[6:0]});
        bus(`OFS_PROD, 1'b0, 32'h0);
        chk(rd, expProd);
        bus(`OFS_MCAND, 1'b0, 32'h0);
        chk(rd, {16'h0, op});
    endtask : sq

    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        bus(`OFS_STAT, 1'b0, 32'h0);
        chk(rd, {30'h0, `RST_MODE});
        bus(8'h40, 1'b0, 32'h0);
        chk(rd, 32'h0);
        bus(`OFS_IRQ_EN, 1'b1, 32'h7);
        bus(`OFS_IRQ_EN, 1'b0, 32'h0);
        chk(rd, 32'h7);
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            setShift(2'(m), 1'b0);
            sq(16'h521e, 16'h001e);
            sq(16'h521e, 16'h001e);
        end
        setShift(2'h1, 1'b1);
        $display("test shift modes done");
        @(posedge mclk);
        lsValid <= 1'b1;
        lsWord <= 16'h0002;
        @(posedge mclk);
        lsValid <= 1'b0;
        #1;
        expMode = 2'h2;
        chk({30'h0, mode}, 32'h2);
        bus(`OFS_STAT, 1'b0, 32'h0);
        chk({30'h0, rd[1:0]}, 32'h2);
        sq(16'h5310, 16'h0010);
        sq(16'h5385, 16'hffff);
        sq(16'h5385, 16'hffff);
        $display("test load and subtract done");
        bus(`OFS_CTRL, 1'b1, 32'h1);
        sat = 1'b1;
        setShift(2'h0, 1'b0);
        for (int i = 0; i < 5; i++) sq(16'h5240, 16'h8000);
        bus(`OFS_STAT, 1'b0, 32'h0);
        chk({31'h0, rd[2]}, {31'h0, expWrap});
        chk({31'h0, irq}, 32'h1);
        bus(`OFS_IRQ_EN, 1'b1, 32'h0);
        repeat (2) @(posedge mclk);
        #1;
        chk({31'h0, irq}, 32'h0);
        bus(`OFS_IRQ_EN, 1'b1, 32'h7);
        bus(`OFS_IRQ_CLR, 1'b1, 32'h7);
        bus(`OFS_STAT, 1'b1, 32'h4);
        repeat (2) @(posedge mclk);
        #1;
        chk({30'h0, irq, wrap}, 32'h0);
        bus(`OFS_IRQ_STAT, 1'b0, 32'h0);
        chk(rd, 32'h0);
        $display("test saturation and interrupt done");
        testDone();
    end
endmodule : product_shift_square_mac_test
